// ===== design/wdk_pkg.sv
/*
  Constants for the key-protected watchdog: register indices, field
  positions, reset values, key values and the access-key states.
  Assumes nothing; used by the watchdog core and the testbench.
*/
package wdk_pkg;

  // Register indices; the APB byte address is four times the index
  localparam logic [7:0] IDX_RESET_CAUSE = 8'hA1;
  localparam logic [7:0] IDX_CONTROL     = 8'hB6;
  localparam logic [7:0] IDX_REFRESH     = 8'hB7;
  localparam logic [7:0] IDX_ACCESS_KEY  = 8'hF7;
  localparam logic [7:0] IDX_IRQ_FLAG    = 8'h97;
  localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h9A;

  // Reset values
  localparam logic [7:0] CONTROL_RESET   = 8'h04;
  localparam logic [3:0] DIVIDER_RESET   = 4'h4;
  localparam logic [7:0] CAUSE_RESET     = 8'h00;

  // watchdog_control fields
  localparam int CTRL_ACTION_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 5;
  localparam int CTRL_DIV_MSB    = 3;
  localparam int CTRL_DIV_LSB    = 0;

  // reset_cause_flags fields
  localparam int CAUSE_PIN_BIT   = 4;
  localparam int CAUSE_GUARD_BIT = 3;
  localparam int CAUSE_SW_BIT    = 2;
  localparam int CAUSE_LV_BIT    = 1;
  localparam int CAUSE_POR_BIT   = 0;

  // Interrupt flag and enable share one bit position
  localparam int IRQ_BIT         = 1;

  // Key values
  localparam logic [7:0] REFRESH_KEY     = 8'h55;
  localparam logic [7:0] ACCESS_KEY_1    = 8'h55;
  localparam logic [7:0] ACCESS_KEY_2    = 8'hAA;
  localparam logic [7:0] ACCESS_KEY_3    = 8'h5A;

  // Cycles the fuse synchroniser needs before the option is trusted
  localparam logic [1:0] FUSE_SETTLE     = 2'h3;

  // Nominal RC oscillator rate, for reference only
  localparam int RC_FREQ_HZ = 23000;

  typedef enum logic [1:0] {
    WDK_KEY_IDLE = 2'b00,
    WDK_KEY_GOT1 = 2'b01,
    WDK_KEY_GOT2 = 2'b11,
    WDK_KEY_OPEN = 2'b10
  } wdk_key_state_t;

endpackage

// ===== design/wdk_guard.sv
/*
  Key-protected watchdog with APB register access.
  Assumes i_sys_clk keeps running whenever the watchdog must count (the
  RC tick arrives on a pin and is sampled on this clock), a chip reset
  controller that acts on o_mcu_reset_req and reports other resets on
  i_mcu_reset, and an APB master on the same clock.
*/
// Our own choice: register access over APB.
`timescale 1ns/1ps

module wdk_guard #(
  parameter int CNT_W = 8,
  parameter int DIV_W = 4
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_clk_en,
  input  wire logic        i_rc_osc,
  input  wire logic        i_fuse_disable,
  input  wire logic        i_mcu_reset,
  input  wire logic        i_pin_reset_evt,
  input  wire logic        i_sw_reset_evt,
  input  wire logic        i_lv_reset_evt,
  input  wire logic        i_por_evt,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_mcu_reset_req,
  output logic             o_guard_irq,
  output logic             o_guard_running
);

  localparam int PRE_W = (1 << DIV_W) - 1;

  // Elaboration-time checks of the parameters
  if (CNT_W < 2 || CNT_W > 8) begin : g_bad_cnt
    $error("CNT_W must lie between 2 and 8");
  end
  if (DIV_W < 1 || DIV_W > 4) begin : g_bad_div
    $error("DIV_W must lie between 1 and 4");
  end

  // Pin synchronisers
  logic rc_meta;
  logic rc_sync;
  logic rc_prev;
  logic fuse_meta;
  logic fuse_sync;

  // Register state
  logic [DIV_W-1:0] guard_divider_select;
  logic             guard_soft_enable;
  logic             timeout_action_select;
  logic [4:0]       cause_flags;
  logic             guard_irq_flag;
  logic             guard_irq_enable;
  logic             guard_fuse_disable;
  logic [1:0]       fuse_wait;
  wdk_pkg::wdk_key_state_t key_state;

  // Counting state
  logic [PRE_W-1:0] prescale;
  logic [CNT_W-1:0] guard_counter;

  // Bus decode
  logic       bus_setup_done;
  logic       bus_commit;
  logic       wr_commit;
  logic       lane0;
  logic [7:0] wr_byte;
  logic [7:0] reg_index;
  logic       addr_ok;
  logic       hit_cause;
  logic       hit_control;
  logic       hit_refresh;
  logic       hit_key;
  logic       hit_irq_flag;
  logic       hit_irq_en;
  logic       mapped;
  logic [7:0] read_byte;

  // Internal events
  logic             soft_reset;
  logic             running;
  logic             rc_edge;
  logic [PRE_W-1:0] div_mask;
  logic             guard_tick_clock;
  logic             overflow;
  logic             refresh_hit;
  logic             wr_control;
  logic             wr_key;
  logic             wr_cause;
  logic             wr_irq_flag;
  logic             wr_irq_en;

  assign lane0       = i_pstrb[0];
  assign wr_byte     = i_pwdata[7:0];
  assign reg_index   = i_paddr[9:2];
  assign addr_ok     = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
  assign hit_cause   = addr_ok && (reg_index == wdk_pkg::IDX_RESET_CAUSE);
  assign hit_control = addr_ok && (reg_index == wdk_pkg::IDX_CONTROL);
  assign hit_refresh = addr_ok && (reg_index == wdk_pkg::IDX_REFRESH);
  assign hit_key     = addr_ok && (reg_index == wdk_pkg::IDX_ACCESS_KEY);
  assign hit_irq_flag = addr_ok && (reg_index == wdk_pkg::IDX_IRQ_FLAG);
  assign hit_irq_en  = addr_ok && (reg_index == wdk_pkg::IDX_IRQ_ENABLE);
  assign mapped      = hit_cause | hit_control | hit_refresh | hit_key
                     | hit_irq_flag | hit_irq_en;

  // First access cycle raises pready; the next edge commits the transfer
  assign bus_setup_done = i_psel & i_penable & ~o_pready;
  assign bus_commit     = i_psel & i_penable & o_pready;
  assign wr_commit      = bus_commit & i_pwrite & lane0 & mapped;
  assign wr_control     = wr_commit & hit_control;
  assign wr_key         = wr_commit & hit_key;
  assign wr_cause       = wr_commit & hit_cause;
  assign wr_irq_flag    = wr_commit & hit_irq_flag;
  assign wr_irq_en      = wr_commit & hit_irq_en;

  // Any MCU reset, including our own request
  assign soft_reset = i_mcu_reset | o_mcu_reset_req;

  assign running = guard_soft_enable & ~guard_fuse_disable;

  assign rc_edge = rc_sync & ~rc_prev;

  // Prescaler bits below the divider code must all be ones
  for (genvar b = 0; b < PRE_W; b++) begin : g_mask
    assign div_mask[b] = (b < int'(guard_divider_select));
  end

  assign guard_tick_clock = running & rc_edge
                          & ((prescale & div_mask) == div_mask);
  assign overflow    = guard_tick_clock & (&guard_counter);
  assign refresh_hit = wr_commit & hit_refresh
                     & (wr_byte == wdk_pkg::REFRESH_KEY);

  always_comb begin
    read_byte = 8'h00;
    unique case (1'b1)
      hit_cause: begin
        read_byte = {3'h0, cause_flags};
      end
      hit_control: begin
        read_byte = 8'h00;
        read_byte[wdk_pkg::CTRL_ACTION_BIT] = timeout_action_select;
        read_byte[wdk_pkg::CTRL_ENABLE_BIT] = guard_soft_enable;
        read_byte[DIV_W-1:0] = guard_divider_select;
      end
      hit_irq_flag: begin
        read_byte[wdk_pkg::IRQ_BIT] = guard_irq_flag;
      end
      hit_irq_en: begin
        read_byte[wdk_pkg::IRQ_BIT] = guard_irq_enable;
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
  end

  // Synchronisers: first stage is read by the second only
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rc_meta   <= 1'b0;
      rc_sync   <= 1'b0;
      rc_prev   <= 1'b0;
      fuse_meta <= 1'b1;
      fuse_sync <= 1'b1;
    end else if (i_clk_en) begin
      rc_meta   <= i_rc_osc;
      rc_sync   <= rc_meta;
      rc_prev   <= rc_sync;
      fuse_meta <= i_fuse_disable;
      fuse_sync <= fuse_meta;
    end
  end

  // Fuse option: held disabled until the synchroniser has settled
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      fuse_wait          <= 2'h0;
      guard_fuse_disable <= 1'b1;
    end else if (i_clk_en) begin
      if (soft_reset) begin
        fuse_wait          <= 2'h0;
        guard_fuse_disable <= 1'b1;
      end else if (fuse_wait != wdk_pkg::FUSE_SETTLE) begin
        fuse_wait <= fuse_wait + 2'h1;
        if (fuse_wait + 2'h1 == wdk_pkg::FUSE_SETTLE) begin
          guard_fuse_disable <= fuse_sync;
        end
      end
    end
  end

  // APB answer: one wait state, registered data and error
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (bus_setup_done) begin
        o_pready  <= 1'b1;
        o_pslverr <= ~mapped;
        o_prdata  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, read_byte};
      end else begin
        o_pready  <= 1'b0;
        o_pslverr <= 1'b0;
        o_prdata  <= 32'h0000_0000;
      end
    end
  end

  // Access key sequence
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      key_state <= wdk_pkg::WDK_KEY_IDLE;
    end else if (i_clk_en) begin
      if (soft_reset) begin
        key_state <= wdk_pkg::WDK_KEY_IDLE;
      end else if (wr_control) begin
        key_state <= wdk_pkg::WDK_KEY_IDLE;
      end else if (wr_key) begin
        unique case (key_state)
          wdk_pkg::WDK_KEY_GOT1: begin
            if (wr_byte == wdk_pkg::ACCESS_KEY_2) begin
              key_state <= wdk_pkg::WDK_KEY_GOT2;
            end else if (wr_byte == wdk_pkg::ACCESS_KEY_1) begin
              key_state <= wdk_pkg::WDK_KEY_GOT1;
            end else begin
              key_state <= wdk_pkg::WDK_KEY_IDLE;
            end
          end
          wdk_pkg::WDK_KEY_GOT2: begin
            if (wr_byte == wdk_pkg::ACCESS_KEY_3) begin
              key_state <= wdk_pkg::WDK_KEY_OPEN;
            end else if (wr_byte == wdk_pkg::ACCESS_KEY_1) begin
              key_state <= wdk_pkg::WDK_KEY_GOT1;
            end else begin
              key_state <= wdk_pkg::WDK_KEY_IDLE;
            end
          end
          wdk_pkg::WDK_KEY_IDLE,
          wdk_pkg::WDK_KEY_OPEN: begin
            if (wr_byte == wdk_pkg::ACCESS_KEY_1) begin
              key_state <= wdk_pkg::WDK_KEY_GOT1;
            end else begin
              key_state <= wdk_pkg::WDK_KEY_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Control register; writes land only while access is open
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      guard_divider_select  <= DIV_W'(wdk_pkg::DIVIDER_RESET);
      guard_soft_enable     <= 1'b0;
      timeout_action_select <= 1'b0;
    end else if (i_clk_en) begin
      if (soft_reset) begin
        guard_divider_select  <= DIV_W'(wdk_pkg::DIVIDER_RESET);
        guard_soft_enable     <= 1'b0;
        timeout_action_select <= 1'b0;
      end else if (wr_control && key_state == wdk_pkg::WDK_KEY_OPEN) begin
        guard_divider_select  <= wr_byte[DIV_W-1:0];
        timeout_action_select <= wr_byte[wdk_pkg::CTRL_ACTION_BIT];
        // Once set, enable stays set until a reset
        guard_soft_enable <= guard_soft_enable
                           | wr_byte[wdk_pkg::CTRL_ENABLE_BIT];
      end
    end
  end

  // Prescaler and counter; refresh restarts both from zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      prescale      <= '0;
      guard_counter <= '0;
    end else if (i_clk_en) begin
      if (soft_reset || !running || refresh_hit) begin
        prescale      <= '0;
        guard_counter <= '0;
      end else begin
        if (rc_edge) begin
          prescale <= prescale + PRE_W'(1);
        end
        if (guard_tick_clock) begin
          // Wraps to zero on overflow, so interrupt mode keeps timing
          guard_counter <= guard_counter + CNT_W'(1);
        end
      end
    end
  end

  // Reset request pulse for the chip reset controller
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_mcu_reset_req <= 1'b0;
    end else if (i_clk_en) begin
      o_mcu_reset_req <= overflow & ~timeout_action_select
                       & ~soft_reset;
    end
  end

  // Reset cause flags: a set beats a software clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cause_flags <= wdk_pkg::CAUSE_RESET[4:0];
    end else if (i_clk_en) begin
      // Software clears a flag by writing zero to it
      cause_flags <= (wr_cause ? (cause_flags & wr_byte[4:0]) : cause_flags)
                   | {i_pin_reset_evt,
                      overflow & ~timeout_action_select & ~soft_reset,
                      i_sw_reset_evt,
                      i_lv_reset_evt,
                      i_por_evt};
    end
  end

  // Interrupt flag and enable; the flag is cleared by writing zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      guard_irq_flag   <= 1'b0;
      guard_irq_enable <= 1'b0;
    end else if (i_clk_en) begin
      if (soft_reset) begin
        guard_irq_flag   <= 1'b0;
        guard_irq_enable <= 1'b0;
      end else begin
        guard_irq_flag <= (overflow & timeout_action_select)
                        | (guard_irq_flag
                           & ~(wr_irq_flag
                               & ~wr_byte[wdk_pkg::IRQ_BIT]));
        if (wr_irq_en) begin
          guard_irq_enable <= wr_byte[wdk_pkg::IRQ_BIT];
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_guard_irq     <= 1'b0;
      o_guard_running <= 1'b0;
    end else if (i_clk_en) begin
      o_guard_irq     <= guard_irq_flag & guard_irq_enable;
      o_guard_running <= running;
    end
  end

endmodule

// ===== sim/wdk_guard_sva.sv
/*
  Port assertions for the key-protected watchdog.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module wdk_guard_sva #(
  parameter int CNT_W = 8,
  parameter int DIV_W = 4
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_mcu_reset,
  input  wire logic [31:0] o_prdata,
  input  wire logic        o_pready,
  input  wire logic        o_pslverr,
  input  wire logic        o_mcu_reset_req,
  input  wire logic        o_guard_irq,
  input  wire logic        o_guard_running
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  a_ready_one_wait: assert property (
    i_psel && i_penable && !o_pready |=> o_pready) else $error("no answer");
  a_ready_single: assert property (
    o_pready |=> !o_pready) else $error("ready held too long");
  a_err_with_ready: assert property (
    o_pslverr |-> o_pready) else $error("error without ready");
  a_rdata_idle: assert property (
    !o_pready |-> o_prdata == 32'h0) else $error("read data outside answer");
  a_req_pulse: assert property (
    o_mcu_reset_req |=> !o_mcu_reset_req) else $error("request too long");
  a_req_from_run: assert property (
    o_mcu_reset_req |-> $past(o_guard_running)) else $error("request idle");
  // Soft resets drop the running level one cycle late, hence the pasts
  a_run_kept: assert property (
    o_guard_running && !o_mcu_reset_req && !$past(o_mcu_reset_req)
    && !i_mcu_reset && !$past(i_mcu_reset) |=> o_guard_running)
    else $error("watchdog stopped");
  a_reset_idle: assert property (
    $rose(i_rstn) |-> !o_guard_running && !o_guard_irq ##1 !o_guard_running)
    else $error("not idle after reset");
  a_irq_from_run: assert property (
    $rose(o_guard_irq) |-> $past(o_guard_running)) else $error("stray irq");

  c_reset_req: cover property (o_mcu_reset_req);
  c_irq: cover property (o_guard_irq);
  c_err: cover property (o_pready && o_pslverr);
endmodule

bind wdk_guard wdk_guard_sva #(.CNT_W(CNT_W), .DIV_W(DIV_W)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel),
  .i_penable(i_penable), .i_mcu_reset(i_mcu_reset), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_mcu_reset_req(o_mcu_reset_req), .o_guard_irq(o_guard_irq),
  .o_guard_running(o_guard_running));

// ===== sim/testbench.sv
/*
  Self-checking bench for the key-protected watchdog.
  Assumes one APB wait state; the RC tick toggles every two clocks.
*/
`timescale 1ns/1ps

module testbench;
  localparam int CW = 4;
  localparam logic [11:0] A_CS = {2'b00, wdk_pkg::IDX_RESET_CAUSE, 2'b00};
  localparam logic [11:0] A_CT = {2'b00, wdk_pkg::IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_RF = {2'b00, wdk_pkg::IDX_REFRESH, 2'b00};
  localparam logic [11:0] A_KY = {2'b00, wdk_pkg::IDX_ACCESS_KEY, 2'b00};
  localparam logic [11:0] A_IF = {2'b00, wdk_pkg::IDX_IRQ_FLAG, 2'b00};
  localparam logic [11:0] A_IE = {2'b00, wdk_pkg::IDX_IRQ_ENABLE, 2'b00};
  logic        clk, rstn, fuse, mrst, psel, pen, pwr, prdy, perr, e;
  logic        req, irq, run, ce;
  logic [3:0]  evt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0]  rcd = 2'b00;
  logic [7:0]  v;
  logic [7:0]  bad[4] = '{8'h55, 8'hAA, 8'h33, 8'h5A};
  logic [7:0]  cbit[4] = '{8'h10, 8'h04, 8'h02, 8'h01};
  int          err_total, samples_checked, reqs, n, n0, seed;
  time         t0;

  wdk_guard #(.CNT_W(CW), .DIV_W(4)) dut_u (
    .i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(ce), .i_rc_osc(rcd[1]),
    .i_fuse_disable(fuse), .i_mcu_reset(mrst), .i_pin_reset_evt(evt[0]),
    .i_sw_reset_evt(evt[1]), .i_lv_reset_evt(evt[2]), .i_por_evt(evt[3]),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(prdy),
    .o_pslverr(perr), .o_mcu_reset_req(req), .o_guard_irq(irq),
    .o_guard_running(run));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Reset requests are counted so that quiet spans can be checked
  always @(posedge clk) begin
    rcd <= rcd + 2'd1;
    if (req === 1'b1) reqs <= reqs + 1;
  end

  function automatic int span(input int d);
    return (1 << CW) * (1 << d) * 4;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    r = prdata;
    e = perr;
    chk(n < 16, 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h0, x});
  endtask

  task automatic unlock;
    apb(1'b1, A_KY, wdk_pkg::ACCESS_KEY_1);
    apb(1'b1, A_KY, wdk_pkg::ACCESS_KEY_2);
    apb(1'b1, A_KY, wdk_pkg::ACCESS_KEY_3);
  endtask

  task automatic rst;
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    {rstn, fuse, mrst, psel, pen, pwr, evt} = '0;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = $urandom(41708);
    rst();
    rd(A_CT, 8'h04);
    rd(A_CS, 8'h00);
    apb(1'b0, 12'h100, 8'h00);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    apb(1'b1, A_CT, 8'h2F);
    rd(A_CT, 8'h04);
    foreach (bad[i]) apb(1'b1, A_KY, bad[i]);
    apb(1'b1, A_CT, 8'h2F);
    rd(A_CT, 8'h04);
    for (int c = 0; c < 16; c++) begin
      v = {1'b0, 1'($urandom), 2'b00, 4'(c)};
      unlock();
      apb(1'b1, A_CT, v);
      apb(1'b1, A_CT, v ^ 8'h0F);
      rd(A_CT, v);
    end
    for (int d = 0; d < 3; d++) begin
      unlock();
      apb(1'b1, A_CT, 8'h20 | 8'(d));
      rd(A_CT, 8'h20 | 8'(d));
      chk(run, 1'b1);
      n0 = reqs;
      repeat (4) begin
        repeat (span(d) / 4) @(posedge clk);
        apb(1'b1, A_RF, wdk_pkg::REFRESH_KEY);
      end
      chk(reqs, n0);
      t0 = $time;
      apb(1'b1, A_RF, 8'($urandom) | 8'h80);
      while (req !== 1'b1 && $time - t0 < 8 * (span(d) + 40)) @(posedge clk);
      n = int'(($time - t0) / 8);
      chk(n >= span(d) - 4 && n <= span(d) + 12, 1'b1);
      repeat (3) @(posedge clk);
      chk(run, 1'b0);
      rd(A_CT, 8'h04);
      rd(A_CS, 8'h08);
      apb(1'b1, A_CS, 8'h00);
      rd(A_CS, 8'h00);
    end
    apb(1'b1, A_IE, 8'h02);
    unlock();
    apb(1'b1, A_CT, 8'h60);
    unlock();
    apb(1'b1, A_CT, 8'h40);
    rd(A_CT, 8'h60);
    n0 = reqs;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(irq, 1'b1);
    chk(reqs, n0);
    rd(A_IF, 8'h02);
    // A low clock enable must hold off even a chip reset
    ce <= 1'b0;
    mrst <= 1'b1;
    repeat (2) @(posedge clk);
    mrst <= 1'b0;
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk(run, 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, A_IE, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, A_IF, 8'h00);
    apb(1'b1, A_IE, 8'h02);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    mrst <= 1'b1;
    @(posedge clk);
    mrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(run, 1'b0);
    rd(A_CT, 8'h04);
    fuse <= 1'b1;
    rst();
    unlock();
    apb(1'b1, A_CT, 8'h20);
    n0 = reqs;
    repeat (200) @(posedge clk);
    chk(run, 1'b0);
    chk(reqs, n0);
    fuse <= 1'b0;
    v = 8'h00;
    for (int i = 0; i < 4; i++) begin
      evt <= 4'(1 << i);
      @(posedge clk);
      evt <= 4'h0;
      v = v | cbit[i];
      rd(A_CS, v);
    end
    rst();
    rd(A_CS, 8'h00);
    complete_run();
  end

  initial begin
    #400us;
    err_total++;
    complete_run();
  end
endmodule
